// File: hdl/msfm_pkg.sv
// constants, carriers and the fcs step for the mac service frame mapper
// assumes one port clock; the relay side and mac side share that clock
// Overview of operation
// - cd transmit: preamble and sfd precede frame
// - cd receive: check fcs, split into indication
// - cd indication: user data, no-response constants
// - addresses carried in da and sa fields
// - cd: length field holds payload octet count
// - cd transmit: request priority is dropped
// - cd indication priority is port default priority
// - cd fcs covers da, sa, length, data, pad
// - missing fcs is computed, supplied fcs kept
// - supplied fcs must cover pad; pad kept
// - token bus: queue request, add delimiters
// - token bus: one indication per valid frame
// - token bus fc bits 1-2 give class
// - token bus fc bits 3-5 give action
// - token bus fc bits 6-8 give priority
// - token bus fcs covers fc, da, sa, data
// - token bus payload in mac data unit field
// - default priority is zero after reset
// - priorities lie in 0..7, three bits
package msfm_pkg;
    localparam logic [7:0] MSFM_CD_PRE = 8'h55;
    localparam logic [7:0] MSFM_CD_SFD = 8'hD5;
    // token bus delimiter symbols are stand-in octets for the phy
    localparam logic [7:0] MSFM_TB_PRE = 8'h55;
    localparam logic [7:0] MSFM_TB_SD = 8'hA5;
    localparam logic [7:0] MSFM_TB_ED = 8'h5A;
    localparam logic [15:0] MSFM_CD_PRE_LEN = 16'h0007;
    localparam logic [15:0] MSFM_TB_PRE_LEN = 16'h0003;
    localparam logic [15:0] MSFM_ADDR_LAST = 16'h0005;
    localparam logic [15:0] MSFM_LEN_LAST = 16'h0001;
    localparam logic [15:0] MSFM_FCS_LAST = 16'h0003;
    localparam logic [15:0] MSFM_MIN_DATA = 16'h002E;
    localparam logic [31:0] MSFM_CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] MSFM_CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] MSFM_CRC_GOOD = 32'hDEBB20E3;
    localparam logic [1:0] MSFM_FF_MAC = 2'h0;
    localparam logic [1:0] MSFM_FF_USER = 2'h1;
    localparam logic [1:0] MSFM_FF_MAC2 = 2'h2;
    localparam logic [1:0] MSFM_FF_RSVD = 2'h3;
    localparam logic [2:0] MSFM_ACT_NORESP = 3'h0;
    localparam logic [2:0] MSFM_ACT_WITHRESP = 3'h1;
    localparam logic [2:0] MSFM_ACT_RESP = 3'h2;
    localparam logic [2:0] MSFM_PRIO_RST = 3'h0;
    localparam logic [15:0] MSFM_CD_HDR = 16'h000E;
    localparam logic [15:0] MSFM_TB_HDR = 16'h000D;
    localparam int MSFM_BUF_W = 9;

    // unit data request; fcs used only when fcs_given
    typedef struct packed {
        logic [1:0] frame_class_bits;
        logic [2:0] action_code_bits;
        logic [47:0] da;
        logic [47:0] sa;
        logic [15:0] len;
        logic [2:0] priority_code_bits;
        logic fcs_given;
        logic [31:0] fcs;
    } msfm_req_t;

    typedef struct packed {
        logic [1:0] frame_class_bits;
        logic [2:0] action_code_bits;
        logic [47:0] da;
        logic [47:0] sa;
        logic [15:0] len;
        logic [2:0] priority_code_bits;
        logic [31:0] fcs;
    } msfm_ind_t;

    function automatic logic [31:0] msfm_crc8(input logic [31:0] c,
                                              input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ MSFM_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// File: hdl/msfm_buf.sv
// two-entry buffer between the transmit framer and the mac transmitter
// assumes the drain side may hold out_ready low for any time
`timescale 1ns/1ps
module msfm_buf import msfm_pkg::*; #(
    parameter int W = MSFM_BUF_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] mem [2];
    logic [W-1:0] next_mem [2];
    logic wptr, rptr, next_wptr, next_rptr;
    logic [1:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rptr];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_mem = mem;
        next_wptr = wptr;
        next_rptr = rptr;
        if (push) begin
            next_mem[wptr] = in_data;
            next_wptr = ~wptr;
        end
        if (pop) begin
            next_rptr = ~rptr;
        end
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wptr <= 1'b0;
            rptr <= 1'b0;
            cnt <= 2'h0;
        end else begin
            mem <= next_mem;
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
        end
    end

    buf_hold_a: assert property (@(posedge clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer dropped a stalled word");
endmodule

// File: hdl/msfm_mapper.sv
// maps unit data requests onto mac frames and received frames back
// assumes mac_type_tbus is static while traffic flows; rx bytes arrive
// from same-clock mac receive logic without preamble, ending in the fcs
`timescale 1ns/1ps
module msfm_mapper import msfm_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic mac_type_tbus,
    input wire logic prio_set,
    input wire logic [2:0] prio_value,
    input wire logic req_valid,
    input wire msfm_req_t req_hdr,
    output logic req_ready,
    input wire logic pay_valid,
    input wire logic [7:0] pay_data,
    output logic pay_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic ind_pay_valid,
    output logic [7:0] ind_pay_data,
    output logic ind_valid,
    output msfm_ind_t ind_hdr,
    output logic ind_drop,
    output logic [15:0] drop_count,
    output logic [2:0] default_prio
);
    typedef enum logic [3:0] {
        T_IDLE, T_PRE, T_SFD, T_FC, T_DA, T_SA, T_LEN, T_DATA, T_PAD,
        T_FCS, T_ED
    } msfm_tx_t;

    msfm_tx_t tstate, next_tstate, nxt;
    msfm_req_t thdr, next_thdr;
    logic [15:0] tcnt, next_tcnt, lim;
    logic [31:0] tcrc, next_tcrc, fcs_v;
    logic [15:0] pad_n;
    logic byte_v, byte_last, in_crc, buf_rdy, step, next_req_ready;
    logic [7:0] byte_d;
    logic [8:0] buf_out;

    // short cd frames are padded with zeros; a supplied fcs must cover them
    assign pad_n = (thdr.len < MSFM_MIN_DATA) ? MSFM_MIN_DATA - thdr.len
                                              : 16'h0000;
    assign fcs_v = thdr.fcs_given ? thdr.fcs : ~tcrc;

    always_comb begin
        next_tstate = tstate;
        next_tcnt = tcnt;
        next_tcrc = tcrc;
        next_thdr = thdr;
        byte_v = 1'b1;
        byte_d = 8'h00;
        byte_last = 1'b0;
        in_crc = 1'b1;
        lim = 16'h0000;
        nxt = T_IDLE;
        pay_ready = 1'b0;
        unique case (tstate)
            T_IDLE: begin
                byte_v = 1'b0;
                if (req_valid) begin
                    next_thdr = req_hdr;
                    next_tstate = T_PRE;
                    next_tcnt = 16'h0000;
                    next_tcrc = MSFM_CRC_INIT;
                end
            end
            T_PRE: begin
                in_crc = 1'b0;
                byte_d = mac_type_tbus ? MSFM_TB_PRE : MSFM_CD_PRE;
                lim = (mac_type_tbus ? MSFM_TB_PRE_LEN : MSFM_CD_PRE_LEN)
                      - 16'h0001;
                nxt = T_SFD;
            end
            T_SFD: begin
                in_crc = 1'b0;
                byte_d = mac_type_tbus ? MSFM_TB_SD : MSFM_CD_SFD;
                nxt = mac_type_tbus ? T_FC : T_DA;
            end
            T_FC: begin
                byte_d = {thdr.frame_class_bits, thdr.action_code_bits,
                          thdr.priority_code_bits};
                nxt = T_DA;
            end
            T_DA: begin
                byte_d = thdr.da[6'd47 - {tcnt[2:0], 3'b000} -: 8];
                lim = MSFM_ADDR_LAST;
                nxt = T_SA;
            end
            T_SA: begin
                byte_d = thdr.sa[6'd47 - {tcnt[2:0], 3'b000} -: 8];
                lim = MSFM_ADDR_LAST;
                if (!mac_type_tbus) begin
                    nxt = T_LEN;
                end else begin
                    nxt = (thdr.len != 16'h0000) ? T_DATA : T_FCS;
                end
            end
            T_LEN: begin
                // request priority has no place in this frame
                byte_d = tcnt[0] ? thdr.len[7:0] : thdr.len[15:8];
                lim = MSFM_LEN_LAST;
                if (thdr.len != 16'h0000) begin
                    nxt = T_DATA;
                end else begin
                    nxt = (pad_n != 16'h0000) ? T_PAD : T_FCS;
                end
            end
            T_DATA: begin
                byte_v = pay_valid;
                byte_d = pay_data;
                pay_ready = buf_rdy;
                lim = thdr.len - 16'h0001;
                nxt = (!mac_type_tbus && pad_n != 16'h0000) ? T_PAD : T_FCS;
            end
            T_PAD: begin
                lim = pad_n - 16'h0001;
                nxt = T_FCS;
            end
            T_FCS: begin
                in_crc = 1'b0;
                byte_d = fcs_v[{tcnt[1:0], 3'b000} +: 8];
                lim = MSFM_FCS_LAST;
                byte_last = !mac_type_tbus && tcnt == MSFM_FCS_LAST;
                nxt = mac_type_tbus ? T_ED : T_IDLE;
            end
            T_ED: begin
                in_crc = 1'b0;
                byte_d = MSFM_TB_ED;
                byte_last = 1'b1;
            end
        endcase
        step = byte_v && buf_rdy;
        if (step) begin
            if (in_crc) begin
                next_tcrc = msfm_crc8(tcrc, byte_d);
            end
            if (tcnt == lim) begin
                next_tcnt = 16'h0000;
                next_tstate = nxt;
            end else begin
                next_tcnt = tcnt + 16'h0001;
            end
        end
        next_req_ready = (next_tstate == T_IDLE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tstate <= T_IDLE;
            tcnt <= 16'h0000;
            tcrc <= MSFM_CRC_INIT;
            thdr <= '0;
            req_ready <= 1'b1;
        end else begin
            tstate <= next_tstate;
            tcnt <= next_tcnt;
            tcrc <= next_tcrc;
            thdr <= next_thdr;
            req_ready <= next_req_ready;
        end
    end

    // buffer absorbs a stall so no byte is lost mid-field
    msfm_buf #(.W(MSFM_BUF_W)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(byte_v && tstate != T_IDLE),
        .in_data({byte_last, byte_d}),
        .in_ready(buf_rdy),
        .out_valid(tx_valid),
        .out_data(buf_out),
        .out_ready(tx_ready)
    );
    assign tx_data = buf_out[7:0];
    assign tx_last = buf_out[8];

    // receive side: fcs bytes trail the payload, so hold four back
    logic [15:0] rcnt, next_rcnt, dcnt, next_dcnt, rlen, next_rlen, hoff;
    logic [15:0] p;
    logic [31:0] rcrc, next_rcrc, win, next_win;
    logic [2:0] bfill, next_bfill;
    logic [7:0] fc, next_fc;
    logic [47:0] rda, next_rda, rsa, next_rsa;
    logic next_ind_valid, next_ind_drop, next_pv, good;
    logic [7:0] next_pd;
    logic [2:0] next_dprio;
    logic [15:0] next_drop_count;
    msfm_ind_t next_ind_hdr;

    always_comb begin
        next_rcnt = rcnt;
        next_dcnt = dcnt;
        next_rlen = rlen;
        next_rcrc = rcrc;
        next_win = win;
        next_bfill = bfill;
        next_fc = fc;
        next_rda = rda;
        next_rsa = rsa;
        next_ind_valid = 1'b0;
        next_ind_drop = 1'b0;
        next_pv = 1'b0;
        next_pd = ind_pay_data;
        next_ind_hdr = ind_hdr;
        next_drop_count = drop_count;
        good = 1'b0;
        hoff = mac_type_tbus ? 16'h0001 : 16'h0000;
        p = rcnt - hoff;
        next_dprio = prio_set ? prio_value : default_prio;
        if (rx_valid) begin
            next_rcrc = msfm_crc8(rcnt == 16'h0000 ? MSFM_CRC_INIT : rcrc,
                                  rx_data);
            next_rcnt = rcnt + 16'h0001;
            if (mac_type_tbus && rcnt == 16'h0000) begin
                next_fc = rx_data;
            end else if (p < 16'h0006) begin
                next_rda = {rda[39:0], rx_data};
            end else if (p < 16'h000C) begin
                next_rsa = {rsa[39:0], rx_data};
            end else if (!mac_type_tbus && p < MSFM_CD_HDR) begin
                next_rlen = {rlen[7:0], rx_data};
            end else begin
                next_win = {win[23:0], rx_data};
                if (bfill != 3'h4) begin
                    next_bfill = bfill + 3'h1;
                end else if (mac_type_tbus || dcnt < rlen) begin
                    next_pv = 1'b1;
                    next_pd = win[31:24];
                    next_dcnt = dcnt + 16'h0001;
                end
            end
            if (rx_last) begin
                // count after this octet, so a bare-fcs bus frame passes
                good = next_rcrc == MSFM_CRC_GOOD && next_bfill == 3'h4
                       && (mac_type_tbus || next_dcnt == rlen);
                next_ind_valid = good;
                next_ind_drop = !good;
                if (!good) begin
                    next_drop_count = drop_count + 16'h0001;
                end
                next_ind_hdr.frame_class_bits = mac_type_tbus
                    ? ((fc[7:6] == MSFM_FF_MAC) ? MSFM_FF_MAC2 : fc[7:6])
                    : MSFM_FF_USER;
                next_ind_hdr.action_code_bits = mac_type_tbus ? fc[5:3]
                    : MSFM_ACT_NORESP;
                next_ind_hdr.priority_code_bits = mac_type_tbus ? fc[2:0]
                    : default_prio;
                next_ind_hdr.da = next_rda;
                next_ind_hdr.sa = next_rsa;
                next_ind_hdr.len = next_dcnt;
                next_ind_hdr.fcs = {next_win[7:0], next_win[15:8],
                                    next_win[23:16], next_win[31:24]};
                next_rcnt = 16'h0000;
                next_dcnt = 16'h0000;
                next_bfill = 3'h0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rcnt <= 16'h0000;
            dcnt <= 16'h0000;
            rlen <= 16'h0000;
            rcrc <= MSFM_CRC_INIT;
            win <= 32'h00000000;
            bfill <= 3'h0;
            fc <= 8'h00;
            rda <= '0;
            rsa <= '0;
            ind_valid <= 1'b0;
            ind_drop <= 1'b0;
            ind_pay_valid <= 1'b0;
            ind_pay_data <= 8'h00;
            ind_hdr <= '0;
            drop_count <= 16'h0000;
            default_prio <= MSFM_PRIO_RST;
        end else begin
            rcnt <= next_rcnt;
            dcnt <= next_dcnt;
            rlen <= next_rlen;
            rcrc <= next_rcrc;
            win <= next_win;
            bfill <= next_bfill;
            fc <= next_fc;
            rda <= next_rda;
            rsa <= next_rsa;
            ind_valid <= next_ind_valid;
            ind_drop <= next_ind_drop;
            ind_pay_valid <= next_pv;
            ind_pay_data <= next_pd;
            ind_hdr <= next_ind_hdr;
            drop_count <= next_drop_count;
            default_prio <= next_dprio;
        end
    end

    pre_then_sfd_a: assert property (@(posedge clk) disable iff (rst)
        tstate == T_PRE && step && tcnt == lim |=> tstate == T_SFD)
        else $error("preamble not followed by start delimiter");
    cd_no_fc_a: assert property (@(posedge clk) disable iff (rst)
        !mac_type_tbus && tstate == T_SFD && step |=> tstate == T_DA)
        else $error("priority octet sent on cd frame");
    tb_fc_crc_a: assert property (@(posedge clk) disable iff (rst)
        tstate == T_FC && step
        |=> tcrc == msfm_crc8(MSFM_CRC_INIT, $past(byte_d)))
        else $error("fc octet not in fcs");
    cd_ind_const_a: assert property (@(posedge clk) disable iff (rst)
        ind_valid && !mac_type_tbus |-> ind_hdr.frame_class_bits
        == MSFM_FF_USER && ind_hdr.action_code_bits == MSFM_ACT_NORESP)
        else $error("cd indication constants wrong");
    cd_ind_prio_a: assert property (@(posedge clk) disable iff (rst)
        ind_valid && !mac_type_tbus |-> ind_hdr.priority_code_bits
        == $past(default_prio))
        else $error("cd indication priority not default");
    tb_ind_prio_a: assert property (@(posedge clk) disable iff (rst)
        ind_valid && mac_type_tbus |-> ind_hdr.priority_code_bits
        == $past(fc[2:0]))
        else $error("tb indication priority not from fc");
    bad_fcs_drop_a: assert property (@(posedge clk) disable iff (rst)
        ind_drop |-> !ind_valid && drop_count == $past(drop_count) + 16'h1)
        else $error("bad frame not dropped and counted");
    prio_reset_a: assert property (@(posedge clk)
        $past(rst) && !rst |-> default_prio == MSFM_PRIO_RST)
        else $error("default priority not zero after reset");
    frame_ends_a: assert property (@(posedge clk) disable iff (rst)
        tstate == T_FCS && step && tcnt == lim && mac_type_tbus
        |=> tstate == T_ED)
        else $error("token bus frame lacks end delimiter");

    cd_tx_done_c: cover property (@(posedge clk) disable iff (rst)
        !mac_type_tbus && tx_valid && tx_ready && tx_last);
    tb_tx_done_c: cover property (@(posedge clk) disable iff (rst)
        mac_type_tbus && tx_valid && tx_ready && tx_last);
    rx_good_c: cover property (@(posedge clk) disable iff (rst) ind_valid);
    rx_drop_c: cover property (@(posedge clk) disable iff (rst) ind_drop);
endmodule

// File: verif/msfm_mac_model.sv
// far-side mac transmit model: takes framed octets at its own pace
// assumes the bench drives inputs at the falling edge
`timescale 1ns/1ps
module msfm_mac_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output int frames
);
    logic [7:0] got[$];
    logic [3:0] pace;
    initial begin
        tx_ready = 1'b0;
        pace = 4'h1;
        frames = 0;
    end
    // stalls come in irregular bursts so the buffer fills and drains
    always @(negedge clk) begin
        pace = {pace[2:0], pace[3] ^ pace[2]};
        tx_ready = !rst && (!slow || pace[0]);
    end
    always @(posedge clk) begin
        if (!rst && tx_valid === 1'b1 && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last === 1'b1) begin
                frames++;
            end
        end
    end
endmodule

// File: verif/mac_service_frame_mapper_tb.sv
// self-checking bench: byte queues model framing, crc and indications
// assumes the mapper top and the far-side mac model in the same run
`timescale 1ns/1ps
module mac_service_frame_mapper_tb import msfm_pkg::*;;
    logic clk = 0, rst = 1, tbus = 0, prio_set = 0, slow = 0;
    logic [2:0] prio_value = 0;
    logic req_valid = 0, pay_valid = 0, rx_valid = 0, rx_last = 0;
    msfm_req_t req_hdr = '0;
    logic [7:0] pay_data = 0, rx_data = 0, tx_data, ind_pay_data;
    logic req_ready, pay_ready, tx_valid, tx_last, tx_ready;
    logic ind_pay_valid, ind_valid, ind_drop;
    msfm_ind_t ind_hdr;
    logic [15:0] drop_count;
    logic [2:0] default_prio;
    int errors = 0, checked = 0, f;
    logic [31:0] seed = 32'h4C2FDF10;
    logic [7:0] pay[$], exp[$], rpay[$];
    msfm_req_t h;

    msfm_mapper dut (.clk(clk), .rst(rst), .mac_type_tbus(tbus),
        .prio_set(prio_set), .prio_value(prio_value),
        .req_valid(req_valid), .req_hdr(req_hdr), .req_ready(req_ready),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .ind_pay_valid(ind_pay_valid),
        .ind_pay_data(ind_pay_data), .ind_valid(ind_valid),
        .ind_hdr(ind_hdr), .ind_drop(ind_drop), .drop_count(drop_count),
        .default_prio(default_prio));
    msfm_mac_model mac (.clk(clk), .rst(rst), .slow(slow),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .frames(f));

    always #10 clk = ~clk;
    // mid-cycle sampling: each one-cycle payload pulse seen exactly once
    always @(negedge clk) begin
        if (ind_pay_valid === 1'b1) begin
            rpay.push_back(ind_pay_data);
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // reflected crc, one octet at a time
    function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] d);
        c ^= {24'h000000, d};
        repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
        return c;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic push_be(input logic [47:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) exp.push_back(v[8*i+:8]);
    endtask

    task automatic mk(input int n, input logic given);
        logic [63:0] w;
        logic [31:0] r;
        h = '0;
        w = {rnd(), rnd()};
        h.da = w[47:0];
        w = {rnd(), rnd()};
        h.sa = w[47:0];
        h.len = 16'(n);
        r = rnd();
        h.priority_code_bits = r[2:0];
        h.frame_class_bits = 2'h1;
        h.fcs_given = given;
        h.fcs = rnd();
        pay.delete();
        repeat (n) begin
            r = rnd();
            pay.push_back(r[7:0]);
        end
    endtask

    // whole line-side frame as the mac should see it
    task automatic build();
        logic [31:0] c;
        int s;
        exp.delete();
        c = 32'hFFFFFFFF;
        if (tbus) begin
            repeat (3) exp.push_back(MSFM_TB_PRE);
            exp.push_back(MSFM_TB_SD);
            s = 4;
            exp.push_back({h.frame_class_bits, h.action_code_bits,
                           h.priority_code_bits});
        end else begin
            repeat (7) exp.push_back(MSFM_CD_PRE);
            exp.push_back(MSFM_CD_SFD);
            s = 8;
        end
        push_be(h.da, 6);
        push_be(h.sa, 6);
        if (!tbus) push_be({32'h0, h.len}, 2);
        foreach (pay[i]) exp.push_back(pay[i]);
        // short frames padded so data plus pad reaches 46 octets
        while (!tbus && exp.size() < s + 14 + 46) exp.push_back(8'h00);
        for (int i = s; i < exp.size(); i++) c = crc_step(c, exp[i]);
        c = h.fcs_given ? h.fcs : ~c;
        for (int i = 0; i < 4; i++) exp.push_back(c[8*i+:8]);
        if (tbus) exp.push_back(MSFM_TB_ED);
    endtask

    task automatic send_tx();
        int i, n;
        logic t;
        n = f;
        build();
        @(negedge clk);
        req_hdr = h;
        req_valid = 1;
        do @(posedge clk); while (req_ready !== 1'b1);
        @(negedge clk);
        req_valid = 0;
        i = 0;
        while (i < pay.size()) begin
            pay_valid = 1;
            pay_data = pay[i];
            #1 t = pay_ready;
            @(negedge clk);
            if (t === 1'b1) i++;
        end
        pay_valid = 0;
        while (f == n) @(negedge clk);
        chk(mac.got.size(), exp.size());
        foreach (exp[k]) begin
            chk(mac.got[k], exp[k]);
        end
        if (tbus) chk(mac.got[4], exp[4]);
        if (tbus) chk(mac.got[17], exp[17]);
        mac.got.delete();
    endtask

    task automatic send_rx(input logic bad);
        int k;
        build();
        repeat (tbus ? 4 : 8) void'(exp.pop_front());
        if (tbus) void'(exp.pop_back());
        if (bad) exp[exp.size()-1] ^= 8'h01;
        rpay.delete();
        foreach (exp[i]) begin
            @(negedge clk);
            rx_valid = 1;
            rx_data = exp[i];
            rx_last = (i == exp.size() - 1);
        end
        @(negedge clk);
        rx_valid = 0;
        rx_last = 0;
        for (k = 0; k < 4 && ind_valid !== 1'b1 && ind_drop !== 1'b1; k++)
            @(negedge clk);
        // let the payload collector take the octet launched with the end
        #1;
        chk(ind_valid, !bad);
        chk(ind_drop, bad);
        if (!bad) begin
            chk(ind_hdr.da, h.da);
            chk(ind_hdr.sa, h.sa);
            chk(ind_hdr.len, h.len);
            chk(rpay.size(), pay.size());
            foreach (pay[i]) chk(rpay[i], pay[i]);
        end
        @(negedge clk);
    endtask

    initial begin
        #(20 * 30000);
        errors++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 0;
        chk(req_ready, 1);
        chk(default_prio, 0);
        chk(drop_count, 0);
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            mk(k == 3 ? 50 : 3 + 43 * k[0], k == 2);
            send_tx();
        end
        tbus = 1;
        for (int k = 0; k < 4; k++) begin
            slow = !k[0];
            mk(5 + k, k == 3);
            h.frame_class_bits = k[1:0];
            h.action_code_bits = 3'(k % 3);
            send_tx();
        end
        tbus = 0;
        @(negedge clk);
        prio_set = 1;
        prio_value = 3'h5;
        @(negedge clk);
        prio_set = 0;
        chk(default_prio, 5);
        mk(10, 0);
        send_rx(0);
        chk(ind_hdr.frame_class_bits, MSFM_FF_USER);
        chk(ind_hdr.action_code_bits, MSFM_ACT_NORESP);
        chk(ind_hdr.priority_code_bits, 5);
        chk(ind_hdr.fcs, {exp[14+46+3], exp[14+46+2], exp[14+46+1],
            exp[14+46]});
        mk(50, 0);
        send_rx(1);
        chk(drop_count, 1);
        tbus = 1;
        mk(7, 0);
        h.action_code_bits = MSFM_ACT_WITHRESP;
        h.priority_code_bits = 3'h6;
        send_rx(0);
        chk(ind_hdr.frame_class_bits, MSFM_FF_USER);
        chk(ind_hdr.action_code_bits, MSFM_ACT_WITHRESP);
        chk(ind_hdr.priority_code_bits, 6);
        mk(6, 0);
        h.frame_class_bits = MSFM_FF_MAC;
        h.action_code_bits = MSFM_ACT_RESP;
        h.priority_code_bits = 3'h2;
        send_rx(0);
        chk(ind_hdr.frame_class_bits, MSFM_FF_MAC2);
        chk(ind_hdr.action_code_bits, MSFM_ACT_RESP);
        chk(ind_hdr.priority_code_bits, 2);
        give_verdict();
    end
endmodule
